// >>> pkg/psmc_pkg.sv
// package for the power save mode controller
package psmc_pkg;

  // ************************************
  // clock divider register layout
  // ************************************
  localparam int FAST_IRQ_BIT = 15;
  localparam int DOZE_HI = 14;
  localparam int DOZE_LO = 12;
  localparam int DOZE_ON_BIT = 11;
  localparam logic [2:0] DOZE_RATIO_RST = 3'h0;
  localparam logic DOZE_ON_RST = 1'h0;
  localparam logic FAST_IRQ_RST = 1'h0;
  localparam logic [7:0] DOZE_CNT_RST = 8'h00;

  // ************************************
  // power save instruction operand
  // ************************************
  localparam logic SAVE_OP_SLEEP = 1'h0;
  localparam logic SAVE_OP_IDLE = 1'h1;

  // ************************************
  // types
  // ************************************
  typedef enum logic [2:0] {
    PSMC_RUN = 3'h1,
    PSMC_SLEEP = 3'h2,
    PSMC_IDLE = 3'h4
  } psmc_state_t;

  typedef struct packed {
    logic fast_irq;
    logic [2:0] ratio;
    logic doze_on;
  } psmc_doze_cfg_t;

  typedef struct packed {
    logic md;
    logic en;
    logic sidl;
  } psmc_mod_ctl_t;

endpackage

// >>> hdl/psmc_ctrl.sv
// power save mode controller: sleep, idle, doze and module gating
`timescale 1ns/1ps
// Function
// R1: sleep or idle entered only by the power save instruction; operand selects.
// R2: sleep stops system clock source and on-chip oscillator, halting cpu.
// R3: fail-safe clock monitor kept inactive throughout sleep.
// R4: low-power rc clock runs in sleep when watchdog enabled.
// R5: watchdog count cleared just before sleep entry when enabled.
// R6: sleep disables system-clocked peripherals; external-clocked ones may run.
// R7: sleep exits on enabled interrupt, any reset or watchdog timeout.
// R8: wake from sleep restarts on the clock source active at entry.
// R9: idle stops cpu, system clock stays, peripherals keep running by default.
// R10: watchdog count cleared on idle entry.
// R11: low-power rc clock kept in idle when watchdog or monitor enabled.
// R12: idle exits on enabled interrupt, any reset or watchdog timeout.
// R13: idle wake reapplies cpu clock at once and resumes execution.
// R14: interrupt during the instruction is held until entry completes, then wakes.
// R15: doze keeps system clock, peripherals full rate, cpu slowed and synchronised.
// R16: doze enabled by doze enable bit 11 of clock divider register.
// R17: bits 14:12 select ratio 1:1 to 1:256, default 1:1; code tops out at 1:128.
// R18: return-on-interrupt bit 15 makes interrupt restore full cpu speed.
// R19: module disable bit removes clocks and blocks register access.
// R20: clearing function enable stops module but keeps registers accessible.
// R21: stop-in-idle bit halts module during idle; default keeps running.
// R22: reset exits every mode and restores doze settings to defaults.
module psmc_ctrl #(
  parameter int NUM_MOD = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // instruction and events
  input wire logic save_exec,
  input wire logic save_op,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  input wire logic wdt_enable,
  input wire logic clkmon_enable,
  input wire logic [1:0] active_clk_src,
  // clock divider register write
  input wire logic cdiv_wr,
  input wire logic [15:0] cdiv_wdata,
  // per-module controls
  input wire psmc_pkg::psmc_mod_ctl_t [NUM_MOD-1:0] mod_ctl,
  input wire logic [NUM_MOD-1:0] mod_ext_clk,
  // clock and status outputs
  output logic sysclk_src_en,
  output logic osc_on,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic clkmon_active,
  output logic rcosc_en,
  output logic wdt_clear,
  output logic [1:0] wake_clk_src,
  output logic in_sleep,
  output logic in_idle,
  output logic [15:0] cdiv_rdata,
  output logic [NUM_MOD-1:0] mod_clk_en,
  output logic [NUM_MOD-1:0] mod_reg_access,
  output logic [NUM_MOD-1:0] mod_run
);

  // ************************************
  // state
  // ************************************
  psmc_pkg::psmc_state_t state_ff;
  psmc_pkg::psmc_state_t nxt_state;
  psmc_pkg::psmc_doze_cfg_t cfg_ff;
  logic [7:0] doze_cnt_ff;
  logic [7:0] nxt_doze_cnt;
  logic irq_hold_ff;
  logic irq_fast_ff;
  logic wdt_clear_ff;
  logic [1:0] src_ff;
  logic wake;
  logic [NUM_MOD-1:0] md_vec;
  logic [NUM_MOD-1:0] en_vec;
  logic [NUM_MOD-1:0] sidl_vec;

  function automatic logic [7:0] doze_limit(input logic [2:0] r);
    doze_limit = 8'(({8'h00, 1'b1} << r) - 9'h001);
  endfunction

  // a held interrupt wakes right after entry
  assign wake = irq_pending | irq_hold_ff | wdt_timeout; // R7 R12 R14

  // per-module control bits as flat vectors
  always_comb begin
    for (int i = 0; i < NUM_MOD; i++) begin
      md_vec[i] = mod_ctl[i].md;
      en_vec[i] = mod_ctl[i].en;
      sidl_vec[i] = mod_ctl[i].sidl;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      psmc_pkg::PSMC_RUN: begin
        if (save_exec) begin // R1
          nxt_state = (save_op == psmc_pkg::SAVE_OP_IDLE) ? psmc_pkg::PSMC_IDLE : psmc_pkg::PSMC_SLEEP;
        end
      end
      psmc_pkg::PSMC_SLEEP: begin
        if (wake) begin // R7
          nxt_state = psmc_pkg::PSMC_RUN;
        end
      end
      psmc_pkg::PSMC_IDLE: begin
        if (wake) begin // R12 R13
          nxt_state = psmc_pkg::PSMC_RUN;
        end
      end
      default: nxt_state = psmc_pkg::PSMC_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= psmc_pkg::PSMC_RUN; // R22
    end else begin
      state_ff <= nxt_state;
    end
  end

  // interrupt coincident with the instruction is held until entry done
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_hold_ff <= 1'b0;
    end else if (state_ff == psmc_pkg::PSMC_RUN && save_exec) begin
      irq_hold_ff <= irq_pending; // R14
    end else begin
      irq_hold_ff <= 1'b0;
    end
  end

  // watchdog clear pulse on entry
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wdt_clear_ff <= 1'b0;
    end else begin
      wdt_clear_ff <= (state_ff == psmc_pkg::PSMC_RUN) && save_exec
        && (wdt_enable || save_op == psmc_pkg::SAVE_OP_IDLE); // R5 R10
    end
  end

  // clock source latched at sleep entry
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      src_ff <= 2'h0;
    end else if (state_ff == psmc_pkg::PSMC_RUN) begin
      src_ff <= active_clk_src; // R8
    end
  end

  // ************************************
  // doze configuration and divider
  // ************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_ff.fast_irq <= psmc_pkg::FAST_IRQ_RST; // R22
      cfg_ff.ratio <= psmc_pkg::DOZE_RATIO_RST; // R17
      cfg_ff.doze_on <= psmc_pkg::DOZE_ON_RST;
    end else if (cdiv_wr) begin
      cfg_ff.fast_irq <= cdiv_wdata[psmc_pkg::FAST_IRQ_BIT]; // R18
      cfg_ff.ratio <= cdiv_wdata[psmc_pkg::DOZE_HI:psmc_pkg::DOZE_LO]; // R17
      cfg_ff.doze_on <= cdiv_wdata[psmc_pkg::DOZE_ON_BIT]; // R16
    end
  end

  // full speed after interrupt until doze is rewritten
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_fast_ff <= 1'b0;
    end else if (irq_pending && cfg_ff.fast_irq && cfg_ff.doze_on) begin
      irq_fast_ff <= 1'b1; // R18
    end else if (cdiv_wr) begin
      irq_fast_ff <= 1'b0;
    end
  end

  always_comb begin
    if (!cfg_ff.doze_on || irq_fast_ff || doze_cnt_ff >= doze_limit(cfg_ff.ratio)) begin
      nxt_doze_cnt = psmc_pkg::DOZE_CNT_RST;
    end else begin
      nxt_doze_cnt = doze_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      doze_cnt_ff <= psmc_pkg::DOZE_CNT_RST;
    end else begin
      doze_cnt_ff <= nxt_doze_cnt; // R15
    end
  end

  // ************************************
  // outputs
  // ************************************
  // oscillator, monitor and rc clock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sysclk_src_en <= 1'b1;
      osc_on <= 1'b1;
      clkmon_active <= 1'b0;
      rcosc_en <= 1'b0;
    end else begin
      sysclk_src_en <= nxt_state != psmc_pkg::PSMC_SLEEP; // R2
      osc_on <= nxt_state != psmc_pkg::PSMC_SLEEP; // R2
      clkmon_active <= clkmon_enable && nxt_state != psmc_pkg::PSMC_SLEEP; // R3
      rcosc_en <= (nxt_state == psmc_pkg::PSMC_SLEEP) ? wdt_enable : (wdt_enable || clkmon_enable); // R4 R11
    end
  end

  // cpu and peripheral clock gates
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= (nxt_state == psmc_pkg::PSMC_RUN) && (nxt_doze_cnt == psmc_pkg::DOZE_CNT_RST); // R13 R15
      periph_clk_en <= nxt_state != psmc_pkg::PSMC_SLEEP; // R6 R9
    end
  end

  // state flags and wake clock source
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      in_sleep <= 1'b0;
      in_idle <= 1'b0;
      wake_clk_src <= 2'h0;
    end else begin
      in_sleep <= nxt_state == psmc_pkg::PSMC_SLEEP;
      in_idle <= nxt_state == psmc_pkg::PSMC_IDLE;
      wake_clk_src <= src_ff; // R8
    end
  end

  // per-module gating
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mod_clk_en <= '0;
      mod_reg_access <= '0;
      mod_run <= '0;
    end else begin
      for (int i = 0; i < NUM_MOD; i++) begin
        mod_clk_en[i] <= !md_vec[i]
          && (nxt_state != psmc_pkg::PSMC_SLEEP || mod_ext_clk[i]) // R6 R19
          && !(nxt_state == psmc_pkg::PSMC_IDLE && sidl_vec[i]); // R21
        mod_reg_access[i] <= !md_vec[i]; // R19 R20
        mod_run[i] <= !md_vec[i] && en_vec[i] // R20
          && (nxt_state != psmc_pkg::PSMC_SLEEP || mod_ext_clk[i])
          && !(nxt_state == psmc_pkg::PSMC_IDLE && sidl_vec[i]); // R9 R21
      end
    end
  end

  assign wdt_clear = wdt_clear_ff;
  assign cdiv_rdata = {cfg_ff.fast_irq, cfg_ff.ratio, cfg_ff.doze_on, 11'h000};

  // ************************************
  // assertions
  // ************************************
  a_sleep_only_instr: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
    (state_ff == psmc_pkg::PSMC_RUN && !save_exec) |=> state_ff == psmc_pkg::PSMC_RUN)
    else $error("power state left run without instruction");
  a_sleep_entry_op: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
    (state_ff == psmc_pkg::PSMC_RUN && save_exec && save_op == psmc_pkg::SAVE_OP_SLEEP) |=> in_sleep && !in_idle)
    else $error("sleep operand did not enter sleep");
  a_idle_entry_op: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
    (state_ff == psmc_pkg::PSMC_RUN && save_exec && save_op == psmc_pkg::SAVE_OP_IDLE) |=> in_idle && !in_sleep)
    else $error("idle operand did not enter idle");

  a_sleep_osc_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
    (state_ff == psmc_pkg::PSMC_SLEEP && !wake) |=> !osc_on && !sysclk_src_en)
    else $error("oscillator running in sleep");
  a_clkmon_sleep_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
    in_sleep |-> !clkmon_active)
    else $error("clock monitor active in sleep");
  a_rcosc_sleep_wdt: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
    (in_sleep && $past(wdt_enable)) |-> rcosc_en)
    else $error("rc clock stopped in sleep with watchdog");
  a_rcosc_sleep_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
    (in_sleep && !$past(wdt_enable)) |-> !rcosc_en)
    else $error("rc clock running in sleep without watchdog");
  a_wdt_clear_sleep: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
    (state_ff == psmc_pkg::PSMC_RUN && save_exec && save_op == psmc_pkg::SAVE_OP_SLEEP && wdt_enable) |=> wdt_clear)
    else $error("watchdog not cleared on sleep entry");
  a_sleep_periph_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
    in_sleep |-> !periph_clk_en && !cpu_clk_en)
    else $error("system clocked logic running in sleep");
  a_ext_clk_sleep: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
    in_sleep |-> (mod_clk_en & ~$past(mod_ext_clk)) == '0)
    else $error("internally clocked module running in sleep");
  a_sleep_wake_irq: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    (state_ff == psmc_pkg::PSMC_SLEEP && irq_pending) |=> state_ff == psmc_pkg::PSMC_RUN)
    else $error("no wake from sleep on interrupt");
  a_src_sleep_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // R8
    state_ff == psmc_pkg::PSMC_SLEEP |=> $stable(src_ff))
    else $error("entry clock source lost in sleep");

  a_idle_cpu_stop: assert property (@(posedge clk_sys) disable iff (sys_rst) // R9
    in_idle |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");
  a_idle_clk_kept: assert property (@(posedge clk_sys) disable iff (sys_rst) // R9
    in_idle |-> sysclk_src_en && osc_on)
    else $error("system clock stopped in idle");
  a_wdt_clear_entry: assert property (@(posedge clk_sys) disable iff (sys_rst) // R10
    (state_ff == psmc_pkg::PSMC_RUN && save_exec && save_op == psmc_pkg::SAVE_OP_IDLE) |=> wdt_clear)
    else $error("watchdog not cleared on idle entry");
  a_rcosc_idle_keep: assert property (@(posedge clk_sys) disable iff (sys_rst) // R11
    (in_idle && $past(wdt_enable || clkmon_enable)) |-> rcosc_en)
    else $error("rc clock stopped in idle");
  a_idle_wake_irq: assert property (@(posedge clk_sys) disable iff (sys_rst) // R12
    (state_ff == psmc_pkg::PSMC_IDLE && irq_pending) |=> state_ff == psmc_pkg::PSMC_RUN)
    else $error("no wake from idle on interrupt");
  a_wake_timeout: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7 R12
    (state_ff != psmc_pkg::PSMC_RUN && wdt_timeout) |=> state_ff == psmc_pkg::PSMC_RUN)
    else $error("no wake on watchdog timeout");
  a_wake_cpu_clk: assert property (@(posedge clk_sys) disable iff (sys_rst) // R13
    (state_ff == psmc_pkg::PSMC_IDLE && wake && !cfg_ff.doze_on) |=> cpu_clk_en)
    else $error("cpu clock not back at idle wake");
  a_held_irq_wake: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
    (state_ff == psmc_pkg::PSMC_RUN && save_exec && irq_pending) |=> state_ff != psmc_pkg::PSMC_RUN ##1
      state_ff == psmc_pkg::PSMC_RUN)
    else $error("coincident interrupt not deferred then woken");

  a_doze_periph_full: assert property (@(posedge clk_sys) disable iff (sys_rst) // R15
    !in_sleep |-> periph_clk_en && sysclk_src_en)
    else $error("peripheral clock slowed outside sleep");
  a_doze_off_full: assert property (@(posedge clk_sys) disable iff (sys_rst) // R16
    (state_ff == psmc_pkg::PSMC_RUN && nxt_state == psmc_pkg::PSMC_RUN && !cfg_ff.doze_on) |=> cpu_clk_en)
    else $error("cpu slowed with doze off");
  a_irq_fast_speed: assert property (@(posedge clk_sys) disable iff (sys_rst) // R18
    (irq_fast_ff && nxt_state == psmc_pkg::PSMC_RUN) |=> cpu_clk_en)
    else $error("cpu not at full speed after interrupt");

  a_md_blocks_regs: assert property (@(posedge clk_sys) disable iff (sys_rst) // R19
    ($past(md_vec) & (mod_reg_access | mod_clk_en)) == '0)
    else $error("disabled module still clocked");
  a_reg_access_md: assert property (@(posedge clk_sys) disable iff (sys_rst) // R19 R20
    !$past(sys_rst) |-> mod_reg_access == ~$past(md_vec))
    else $error("register access does not follow disable bit");
  a_run_needs_en: assert property (@(posedge clk_sys) disable iff (sys_rst) // R20
    (mod_run & ~$past(en_vec)) == '0)
    else $error("module running without function enable");
  a_sidl_idle_halt: assert property (@(posedge clk_sys) disable iff (sys_rst) // R21
    in_idle |-> (mod_clk_en & $past(sidl_vec)) == '0)
    else $error("stop in idle module still clocked");
  a_reset_defaults: assert property (@(posedge clk_sys) disable iff (sys_rst) // R22
    $past(sys_rst) |-> cdiv_rdata == 16'h0000 && !in_sleep && !in_idle && cpu_clk_en)
    else $error("reset did not restore defaults");
endmodule

// >>> bench/psmc_ctrl_tb.sv
// self-checking testbench for the power save mode controller
`timescale 1ns/1ps
module psmc_ctrl_tb;
  // ************************************
  // signals
  // ************************************
  typedef struct packed {
    logic op;
    logic wdt;
    logic mon;
    logic by_wdt;
    logic [8:0] exp;
  } psmc_row_t;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic save_exec = 1'h0;
  logic save_op = 1'h0;
  logic irq_pending = 1'h0;
  logic wdt_timeout = 1'h0;
  logic wdt_enable = 1'h0;
  logic clkmon_enable = 1'h0;
  logic [1:0] active_clk_src = 2'h3;
  logic cdiv_wr = 1'h0;
  logic [15:0] cdiv_wdata = 16'h0000;
  psmc_pkg::psmc_mod_ctl_t [7:0] mod_ctl = {3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h6, 3'h2, 3'h0};
  logic [7:0] mod_ext_clk = 8'h10;
  logic sysclk_src_en, osc_on, cpu_clk_en, periph_clk_en, clkmon_active, rcosc_en, wdt_clear;
  logic [1:0] wake_clk_src;
  logic in_sleep, in_idle;
  logic [15:0] cdiv_rdata;
  logic [7:0] mod_clk_en, mod_reg_access, mod_run;
  int n_fail = 0;
  int comparisons = 0;
  int c;
  // rows: operand, watchdog, monitor, wake by timeout, expected clock and status outputs
  psmc_row_t rows [5] = '{{1'h0, 1'h0, 1'h0, 1'h0, 9'h002}, {1'h0, 1'h1, 1'h1, 1'h1, 9'h00e},
    {1'h1, 1'h0, 1'h0, 1'h0, 9'h1a5}, {1'h1, 1'h0, 1'h1, 1'h1, 9'h1bd}, {1'h1, 1'h1, 1'h0, 1'h0, 9'h1ad}};

  psmc_ctrl #(.NUM_MOD(8)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .save_exec(save_exec), .save_op(save_op),
    .irq_pending(irq_pending), .wdt_timeout(wdt_timeout), .wdt_enable(wdt_enable), .clkmon_enable(clkmon_enable),
    .active_clk_src(active_clk_src), .cdiv_wr(cdiv_wr), .cdiv_wdata(cdiv_wdata), .mod_ctl(mod_ctl),
    .mod_ext_clk(mod_ext_clk), .sysclk_src_en(sysclk_src_en), .osc_on(osc_on), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .clkmon_active(clkmon_active), .rcosc_en(rcosc_en), .wdt_clear(wdt_clear),
    .wake_clk_src(wake_clk_src), .in_sleep(in_sleep), .in_idle(in_idle), .cdiv_rdata(cdiv_rdata),
    .mod_clk_en(mod_clk_en), .mod_reg_access(mod_reg_access), .mod_run(mod_run));

  always #4 clk_sys = ~clk_sys;

  // ************************************
  // helpers
  // ************************************
  function logic [8:0] outv();
    return {sysclk_src_en, osc_on, cpu_clk_en, periph_clk_en, clkmon_active, rcosc_en, wdt_clear, in_sleep, in_idle};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim();
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tick();
    @(posedge clk_sys);
    #1;
  endtask
  task issue(input logic op, input logic irq);
    @(posedge clk_sys);
    save_exec <= 1'h1;
    save_op <= op;
    irq_pending <= irq;
    @(posedge clk_sys);
    save_exec <= 1'h0;
    irq_pending <= 1'h0;
    #1;
  endtask
  task wake(input logic by_wdt);
    @(posedge clk_sys);
    wdt_timeout <= by_wdt;
    irq_pending <= !by_wdt;
    @(posedge clk_sys);
    wdt_timeout <= 1'h0;
    irq_pending <= 1'h0;
    #1;
  endtask
  task wrcd(input logic [15:0] d);
    @(posedge clk_sys);
    cdiv_wr <= 1'h1;
    cdiv_wdata <= d;
    @(posedge clk_sys);
    cdiv_wr <= 1'h0;
    #1;
  endtask
  task cnt(input int n, input int exp);
    c = 0;
    repeat (n) begin
      tick();
      c = c + int'(cpu_clk_en === 1'b1);
    end
    chk(16'(c), 16'(exp));
  endtask

  initial begin
    #20000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1;
    chk(outv(), 9'h1e0);
    chk(cdiv_rdata, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      wdt_enable <= rows[i].wdt;
      clkmon_enable <= rows[i].mon;
      repeat (2) tick();
      chk(mod_reg_access, 8'hfb);
      issue(rows[i].op, 1'h0);
      chk(outv(), rows[i].exp);
      chk(mod_clk_en, rows[i].op ? 8'hf3 : 8'h10);
      chk(mod_run, rows[i].op ? 8'hf2 : 8'h10);
      repeat (3) tick();
      chk(outv(), rows[i].exp & 9'h1fb);
      wake(rows[i].by_wdt);
      chk(outv(), {4'hf, rows[i].mon, rows[i].wdt | rows[i].mon, 3'h0});
      chk(mod_run, 8'hfa);
    end
    @(posedge clk_sys);
    active_clk_src <= 2'h2;
    tick();
    issue(1'h0, 1'h0);
    @(posedge clk_sys);
    active_clk_src <= 2'h1;
    tick();
    chk(wake_clk_src, 2'h2);
    issue(1'h1, 1'h0);
    chk({in_sleep, in_idle}, 2'h2);
    wake(1'h0);
    issue(1'h1, 1'h1);
    chk(in_idle, 1'h1);
    tick();
    chk(in_idle, 1'h0);
    for (int r = 0; r < 4; r++) begin
      wrcd({1'h0, 3'(r), 1'h1, 11'h000});
      chk(cdiv_rdata, {1'h0, 3'(r), 1'h1, 11'h000});
      cnt(32, 32 >> r);
      chk(periph_clk_en, 1'h1);
    end
    wrcd(16'h3000);
    cnt(8, 8);
    wrcd(16'h9800);
    cnt(8, 4);
    wake(1'h0);
    cnt(8, 8);
    wrcd(16'h1800);
    wake(1'h0);
    cnt(8, 4);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1;
    chk(cdiv_rdata, 16'h0000);
    cnt(8, 8);
    issue(1'h0, 1'h0);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1;
    chk(outv(), 9'h1e0);
    end_sim();
  end
endmodule
